// *** logic/dps_sem_host.sv ***
// Port controller that takes, tests, releases and clears token flags.
// Assumes the device port pins are wired to pins and dq_in directly.
// Operation
// - Flags are active low: write zero to request, one to release.
// - Select low reaches token space; address, read and write act as RAM.
// - Between polling reads drop select or output enable.
// - Request by writing zero, then read back; zero means owned.
// - After a failed request keep reading or write one to withdraw.
// - Software writes one to all eight flags at start-up.
// - Hold chip enable high while select is low for token access.
`timescale 1ns/1ps
module dps_sem_host
	import dps_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire dps_cmd_t cmd,
	output logic rsp_valid,
	output dps_rsp_t rsp,
	output dps_pins_t pins,
	input wire logic [DATA_W-1:0] dq_in
);

	typedef enum logic [2:0] {
		M_IDLE,
		M_ACQ_WR,
		M_ACQ_RD,
		M_WITHDRAW,
		M_RELEASE,
		M_TEST,
		M_INIT
	} dps_main_t;

	logic rst_meta_reg, rst_sync_reg, rst_n;

	// Reset takes hold at once but lifts only on the clock, so no flop
	// leaves reset on a different edge from its neighbours.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_reg <= 1'h0;
			rst_sync_reg <= 1'h0;
		end else begin
			rst_meta_reg <= 1'h1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	assign rst_n = rst_sync_reg;

	dps_main_t state_reg, state_next;
	dps_cmd_t cmd_reg, cmd_next;
	logic [IDX_W-1:0] idx_reg, idx_next;
	logic issued_reg, issued_next;
	logic rsp_valid_reg, rsp_valid_next;
	dps_rsp_t rsp_reg, rsp_next;
	logic wrote_zero_reg, wrote_zero_next;
	logic withdrew_reg, withdrew_next;
	logic [IDX_W:0] init_cnt_reg, init_cnt_next;

	logic eng_start, eng_write, eng_wbit, eng_busy, eng_done, eng_rbit;

	assign cmd_ready = (state_reg == M_IDLE);
	assign eng_start = (state_reg != M_IDLE) && !issued_reg;
	assign eng_write = (state_reg != M_ACQ_RD) && (state_reg != M_TEST);
	// Only a request writes zero; every other write frees the latch.
	assign eng_wbit = (state_reg == M_ACQ_WR) ? FLAG_TAKE : FLAG_FREE;

	dps_pin_cycle u_cycle (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.start(eng_start),
		.is_write(eng_write),
		.index(idx_reg),
		.wbit(eng_wbit),
		.dq_in(dq_in),
		.busy(eng_busy),
		.done(eng_done),
		.rbit(eng_rbit),
		.pins(pins)
	);

	always_comb begin
		state_next = state_reg;
		cmd_next = cmd_reg;
		idx_next = idx_reg;
		issued_next = issued_reg;
		rsp_valid_next = 1'h0;
		rsp_next = rsp_reg;
		wrote_zero_next = wrote_zero_reg;
		withdrew_next = withdrew_reg;
		init_cnt_next = init_cnt_reg;
		if (eng_done) begin
			issued_next = 1'h0;
		end else if (eng_start) begin
			issued_next = 1'h1;
		end
		unique case (state_reg)
			M_IDLE: begin
				wrote_zero_next = 1'h0;
				withdrew_next = 1'h0;
				init_cnt_next = '0;
				if (cmd_valid) begin
					cmd_next = cmd;
					idx_next = cmd.index;
					unique case (cmd.op)
						OP_ACQUIRE: state_next = M_ACQ_WR;
						OP_RELEASE: state_next = M_RELEASE;
						OP_TEST: state_next = M_TEST;
						OP_INIT: begin
							state_next = M_INIT;
							idx_next = IDX_FIRST;
						end
					endcase
				end
			end
			M_ACQ_WR: begin
				if (eng_done) begin
					// Read back only after the request is written.
					wrote_zero_next = 1'h1;
					state_next = M_ACQ_RD;
				end
			end
			M_ACQ_RD: begin
				if (eng_done) begin
					if (eng_rbit == FLAG_TAKE) begin
						rsp_valid_next = 1'h1;
						rsp_next = '{granted: 1'h1, flag_bit: FLAG_TAKE};
						state_next = M_IDLE;
					end else if (cmd_reg.polls != POLL_ZERO) begin
						// Repeated reads keep the request live and honest.
						cmd_next.polls = cmd_reg.polls - 8'h01;
					end else begin
						// A stale request would seize the flag later.
						state_next = M_WITHDRAW;
					end
				end
			end
			M_WITHDRAW: begin
				if (eng_done) begin
					withdrew_next = 1'h1;
					rsp_valid_next = 1'h1;
					rsp_next = '{granted: 1'h0, flag_bit: FLAG_FREE};
					state_next = M_IDLE;
				end
			end
			M_RELEASE: begin
				if (eng_done) begin
					rsp_valid_next = 1'h1;
					rsp_next = '{granted: 1'h0, flag_bit: FLAG_FREE};
					state_next = M_IDLE;
				end
			end
			M_TEST: begin
				if (eng_done) begin
					rsp_valid_next = 1'h1;
					rsp_next = '{granted: eng_rbit == FLAG_TAKE,
						flag_bit: eng_rbit};
					state_next = M_IDLE;
				end
			end
			M_INIT: begin
				if (eng_done) begin
					init_cnt_next = init_cnt_reg + 4'h1;
					if (idx_reg == IDX_LAST) begin
						rsp_valid_next = 1'h1;
						rsp_next = '{granted: 1'h0, flag_bit: FLAG_FREE};
						state_next = M_IDLE;
					end else begin
						idx_next = idx_reg + 3'h1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= M_IDLE;
			cmd_reg <= '{op: OP_TEST, index: 3'h0, polls: 8'h00};
			idx_reg <= IDX_FIRST;
			issued_reg <= 1'h0;
			rsp_valid_reg <= 1'h0;
			rsp_reg <= '{granted: 1'h0, flag_bit: FLAG_FREE};
			wrote_zero_reg <= 1'h0;
			withdrew_reg <= 1'h0;
			init_cnt_reg <= '0;
		end else begin
			state_reg <= state_next;
			cmd_reg <= cmd_next;
			idx_reg <= idx_next;
			issued_reg <= issued_next;
			rsp_valid_reg <= rsp_valid_next;
			rsp_reg <= rsp_next;
			wrote_zero_reg <= wrote_zero_next;
			withdrew_reg <= withdrew_next;
			init_cnt_reg <= init_cnt_next;
		end
	end

	assign rsp_valid = rsp_valid_reg;
	assign rsp = rsp_reg;

	property p_write_first;
		@(posedge clk_sys) disable iff (!rst_n)
		(state_reg == M_ACQ_RD && eng_start) |-> wrote_zero_reg;
	endproperty
	a_write_first: assert property (p_write_first)
		else $error("Token read issued before the request write.");

	property p_withdraw;
		@(posedge clk_sys) disable iff (!rst_n)
		(rsp_valid_reg && !rsp_reg.granted && cmd_reg.op == OP_ACQUIRE)
			|-> withdrew_reg;
	endproperty
	a_withdraw: assert property (p_withdraw)
		else $error("Failed request reported without withdrawal.");

	property p_init_all;
		@(posedge clk_sys) disable iff (!rst_n)
		(rsp_valid_reg && cmd_reg.op == OP_INIT)
			|-> init_cnt_reg == 4'h8;
	endproperty
	a_init_all: assert property (p_init_all)
		else $error("Clear did not free all eight flags.");

	property p_release_one;
		@(posedge clk_sys) disable iff (!rst_n)
		((state_reg == M_RELEASE || state_reg == M_INIT) && !pins.rw_n)
			|-> pins.dq_out[0] == FLAG_FREE && pins.dq_oe;
	endproperty
	a_release_one: assert property (p_release_one)
		else $error("Release wrote something other than one.");

endmodule

// *** logic/dps_pkg.sv ***
// Constants, command and pin types shared by the semaphore port controller.
// Assumes one 25 MHz system clock and a port wired straight to the device.
package dps_pkg;

	localparam int DATA_W = 16;
	localparam int IDX_W = 3;
	localparam int NUM_FLAGS = 8;
	localparam int POLL_W = 8;
	localparam int CNT_W = 4;

	// Timing in nanoseconds; the clock period sets the cycle counts.
	localparam int CLK_NS = 40;
	localparam int T_ACC_NS = 70;
	localparam int T_WP_NS = 70;
	localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
	localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [CNT_W-1:0] ACC_LAST = CNT_W'(ACC_CYC - 1);
	localparam logic [CNT_W-1:0] WP_LAST = CNT_W'(WP_CYC - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

	localparam logic FLAG_TAKE = 1'h0;
	localparam logic FLAG_FREE = 1'h1;
	localparam logic [IDX_W-1:0] IDX_FIRST = 3'h0;
	localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(NUM_FLAGS - 1);
	localparam logic [POLL_W-1:0] POLL_ZERO = 8'h00;

	typedef enum logic [1:0] {
		OP_ACQUIRE,
		OP_RELEASE,
		OP_TEST,
		OP_INIT
	} dps_op_t;

	typedef struct packed {
		dps_op_t op;
		logic [IDX_W-1:0] index;
		logic [POLL_W-1:0] polls;
	} dps_cmd_t;

	typedef struct packed {
		logic granted;
		logic flag_bit;
	} dps_rsp_t;

	typedef struct packed {
		logic ce_n;
		logic token_space_select_n;
		logic oe_n;
		logic rw_n;
		logic [IDX_W-1:0] flag_index;
		logic [DATA_W-1:0] dq_out;
		logic dq_oe;
	} dps_pins_t;

	localparam dps_pins_t PINS_IDLE = '{
		ce_n: 1'h1,
		token_space_select_n: 1'h1,
		oe_n: 1'h1,
		rw_n: 1'h1,
		flag_index: 3'h0,
		dq_out: 16'h0000,
		dq_oe: 1'h0
	};

endpackage

// *** logic/dps_pin_cycle.sv ***
// One semaphore-space read or write cycle on the device port pins.
// Assumes dq_in is synchronous to clk_sys and rst_n is already synchronised.
`timescale 1ns/1ps
module dps_pin_cycle
	import dps_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic start,
	input wire logic is_write,
	input wire logic [IDX_W-1:0] index,
	input wire logic wbit,
	input wire logic [DATA_W-1:0] dq_in,
	output logic busy,
	output logic done,
	output logic rbit,
	output dps_pins_t pins
);

	typedef enum logic [2:0] {E_IDLE, E_SETUP, E_ACT, E_HOLD, E_GAP} dps_eng_t;

	dps_eng_t state_reg, state_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic wr_reg, wr_next;
	logic rbit_reg, rbit_next;
	logic done_reg, done_next;
	dps_pins_t pins_reg, pins_next;

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		wr_next = wr_reg;
		rbit_next = rbit_reg;
		done_next = 1'h0;
		pins_next = pins_reg;
		unique case (state_reg)
			E_IDLE: begin
				if (start) begin
					state_next = E_SETUP;
					wr_next = is_write;
					pins_next = PINS_IDLE;
					// Chip enable stays high so only the token space is reached.
					pins_next.token_space_select_n = 1'h0;
					pins_next.flag_index = index;
					pins_next.dq_out = {DATA_W{wbit}};
				end
			end
			E_SETUP: begin
				state_next = E_ACT;
				if (wr_reg) begin
					cnt_next = WP_LAST;
					pins_next.rw_n = 1'h0;
					pins_next.dq_oe = 1'h1;
				end else begin
					cnt_next = ACC_LAST;
					pins_next.oe_n = 1'h0;
				end
			end
			E_ACT: begin
				if (cnt_reg == CNT_ZERO) begin
					state_next = E_HOLD;
					pins_next.rw_n = 1'h1;
					pins_next.oe_n = 1'h1;
					if (!wr_reg) begin
						// The flag is spread over every bit, so bit 0 suffices.
						rbit_next = dq_in[0];
					end
				end else begin
					cnt_next = cnt_reg - 4'h1;
				end
			end
			E_HOLD: begin
				state_next = E_GAP;
				// Dropping the select ends the cycle; rbit keeps the captured read value.
				pins_next = PINS_IDLE;
			end
			E_GAP: begin
				state_next = E_IDLE;
				done_next = 1'h1;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= E_IDLE;
			cnt_reg <= CNT_ZERO;
			wr_reg <= 1'h0;
			rbit_reg <= FLAG_FREE;
			done_reg <= 1'h0;
			pins_reg <= PINS_IDLE;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			wr_reg <= wr_next;
			rbit_reg <= rbit_next;
			done_reg <= done_next;
			pins_reg <= pins_next;
		end
	end

	assign busy = (state_reg != E_IDLE);
	assign done = done_reg;
	assign rbit = rbit_reg;
	assign pins = pins_reg;

	property p_ce_high;
		@(posedge clk_sys) disable iff (!rst_n)
		pins_reg.ce_n == 1'h1;
	endproperty
	a_ce_high: assert property (p_ce_high)
		else $error("Chip enable driven low during token access.");

	property p_strobe_sel;
		@(posedge clk_sys) disable iff (!rst_n)
		(!pins_reg.rw_n || !pins_reg.oe_n) |->
			(!pins_reg.token_space_select_n && pins_reg.rw_n != pins_reg.oe_n);
	endproperty
	a_strobe_sel: assert property (p_strobe_sel)
		else $error("Strobe active without select, or both strobes low.");

	property p_read_gap;
		@(posedge clk_sys) disable iff (!rst_n)
		$rose(pins_reg.oe_n) |-> ##1 pins_reg.token_space_select_n;
	endproperty
	a_read_gap: assert property (p_read_gap)
		else $error("Select not released after a token read.");

	property p_wr_len;
		@(posedge clk_sys) disable iff (!rst_n)
		$fell(pins_reg.rw_n) |-> (!pins_reg.rw_n && pins_reg.dq_oe) [*2]
			##1 (pins_reg.rw_n && pins_reg.dq_oe);
	endproperty
	a_wr_len: assert property (p_wr_len)
		else $error("Write pulse length or data hold wrong.");

endmodule

// *** testbench/dps_dev_model.sv ***
// Behavioural model of the token flag device seen from the host port.
// Assumes its host port is wired to the controller pins and that the
// bench drives its far port through a simple one-cycle write strobe.
`timescale 1ns/1ps
module dps_dev_model
	import dps_pkg::*;
(
	input wire logic clk_sys,
	input wire dps_pins_t pins,
	output logic [DATA_W-1:0] dq_in,
	input wire logic r_wr,
	input wire logic [IDX_W-1:0] r_idx,
	input wire logic r_bit,
	output logic [NUM_FLAGS-1:0] r_flag
);
	// Power-up state is deliberately dirty: the host side holds every flag.
	logic [NUM_FLAGS-1:0] req_l = 8'h00;
	logic [NUM_FLAGS-1:0] req_r = 8'hff;
	logic [NUM_FLAGS-1:0] own_l = 8'hff;
	logic [NUM_FLAGS-1:0] own_r = 8'h00;
	logic cap = 1'b1;
	logic rd_prev = 1'b0;
	logic rd_act;

	assign rd_act = !pins.token_space_select_n && !pins.oe_n;
	// A released bus shows the inverse of the last value, never a hold.
	assign dq_in = rd_prev ? {DATA_W{cap}} : {DATA_W{~cap}};
	assign r_flag = ~own_r;

	always @(posedge clk_sys) begin
		// The data bus is updated after the edge so the host's sampling
		// flop never races the model.
		if (rd_act && !rd_prev) begin
			cap <= ~own_l[pins.flag_index];
		end
		rd_prev <= rd_act;
		if (!pins.token_space_select_n && !pins.rw_n) begin
			req_l[pins.flag_index] = pins.dq_out[0];
		end
		if (r_wr) begin
			req_r[r_idx] = r_bit;
		end
		for (int i = 0; i < NUM_FLAGS; i++) begin
			if (own_l[i] && req_l[i]) begin
				own_l[i] = 1'b0;
			end
			if (own_r[i] && req_r[i]) begin
				own_r[i] = 1'b0;
			end
			// Host side wins a same-edge tie; that is the fixed tie-break.
			if (!own_l[i] && !own_r[i]) begin
				if (!req_l[i]) begin
					own_l[i] = 1'b1;
				end else if (!req_r[i]) begin
					own_r[i] = 1'b1;
				end
			end
		end
	end
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench for the token flag port controller.
// Assumes the device model above stands on the pins; the bench plays
// the far port and keeps its own picture of every flag's owner.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((e) !== (g)) begin \
	failures++; $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_top
	import dps_pkg::*;
;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic cmd_valid = 1'b0;
	logic cmd_ready;
	dps_cmd_t cmd = '0;
	logic rsp_valid;
	dps_rsp_t rsp;
	dps_pins_t pins;
	logic [DATA_W-1:0] dq_in;
	logic r_wr = 1'b0;
	logic [IDX_W-1:0] r_idx = 3'h0;
	logic r_bit = 1'b1;
	logic [NUM_FLAGS-1:0] r_flag;
	int failures = 0;
	int samples_checked = 0;
	logic [15:0] seed = 16'hc897;
	int own [NUM_FLAGS];
	logic rreq [NUM_FLAGS];
	// One access costs issue, setup, strobe, hold, gap and done cycles.
	localparam int ACC_T = ACC_CYC + 5;

	always #20 clk_sys = ~clk_sys;

	dps_sem_host dut_u (.clk_sys(clk_sys), .arst_n(arst_n),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
		.rsp_valid(rsp_valid), .rsp(rsp), .pins(pins), .dq_in(dq_in));
	dps_dev_model dev_u (.clk_sys(clk_sys), .pins(pins), .dq_in(dq_in),
		.r_wr(r_wr), .r_idx(r_idx), .r_bit(r_bit), .r_flag(r_flag));

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Owner codes: 0 free, 1 host port, 2 far port.
	task automatic ref_rel(input int i);
		if (own[i] == 1) begin
			own[i] = rreq[i] ? 0 : 2;
		end
	endtask

	task automatic finish_test();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic host(input dps_op_t op, input logic [2:0] i,
		input logic [7:0] p, input bit race);
		logic eg;
		logic ef;
		int lat;
		int n;
		eg = 1'b0;
		ef = 1'b1;
		lat = ACC_T;
		case (op)
			OP_ACQUIRE: begin
				eg = race || own[i] != 2;
				ef = !eg;
				lat = eg ? 2 * ACC_T : (3 + p) * ACC_T;
				if (eg) begin
					own[i] = 1;
				end
			end
			OP_TEST: begin
				ef = own[i] != 1;
				eg = !ef;
			end
			OP_RELEASE: ref_rel(i);
			default: begin
				lat = NUM_FLAGS * ACC_T;
				for (int k = 0; k < NUM_FLAGS; k++) begin
					ref_rel(k);
				end
			end
		endcase
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd <= '{op: op, index: i, polls: p};
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_sys);
			#1;
			n++;
		end while (rsp_valid !== 1'b1 && n < 200);
		`CHK("rsp_seen", 1'b1, rsp_valid)
		`CHK("granted", eg, rsp.granted)
		`CHK("flag_bit", ef, rsp.flag_bit)
		if (!race) begin
			`CHK("latency", lat, n)
		end
		`CHK("cmd_ready", 1'b1, cmd_ready)
		@(posedge clk_sys);
		#1;
		`CHK("rsp_valid", 1'b0, rsp_valid)
	endtask

	task automatic right(input logic [2:0] i, input logic b);
		@(posedge clk_sys);
		r_wr <= 1'b1;
		r_idx <= i;
		r_bit <= b;
		@(posedge clk_sys);
		r_wr <= 1'b0;
		rreq[i] = b;
		if (b && own[i] == 2) begin
			own[i] = 0;
		end
		if (!b && own[i] == 0) begin
			own[i] = 2;
		end
		@(posedge clk_sys);
		#1;
		`CHK("r_flag", own[i] != 2, r_flag[i])
	endtask

	always @(posedge clk_sys) begin
		if (arst_n && pins.token_space_select_n === 1'b0) begin
			`CHK("ce_n", 1'b1, pins.ce_n)
		end
	end

	initial begin
		#(40 * 50000);
		failures++;
		finish_test();
	end

	initial begin
		for (int k = 0; k < NUM_FLAGS; k++) begin
			own[k] = 1;
			rreq[k] = 1'b1;
		end
		repeat (8) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		host(OP_INIT, 3'h0, 8'h00, 0);
		for (int k = 0; k < NUM_FLAGS; k++) begin
			host(OP_TEST, 3'(k), 8'h00, 0);
		end
		host(OP_ACQUIRE, 3'h2, 8'h00, 0);
		right(3'h2, 1'b0);
		host(OP_TEST, 3'h2, 8'h00, 0);
		host(OP_RELEASE, 3'h2, 8'h00, 0);
		host(OP_TEST, 3'h2, 8'h00, 0);
		host(OP_ACQUIRE, 3'h2, 8'h00, 0);
		host(OP_ACQUIRE, 3'h2, 8'h02, 0);
		right(3'h2, 1'b1);
		right(3'h6, 1'b0);
		fork
			host(OP_ACQUIRE, 3'h6, 8'h08, 1);
			begin
				repeat (30) @(posedge clk_sys);
				right(3'h6, 1'b1);
			end
		join
		for (int t = 0; t < 60; t++) begin
			seed = lfsr(seed);
			if (seed[5]) begin
				right(seed[2:0], seed[6]);
			end else begin
				host(dps_op_t'(seed[4:3]), seed[2:0], {6'h00, seed[9:8]}, 0);
			end
		end
		finish_test();
	end
endmodule
